// *** hw/pwm_sync_defines.vh ***
`ifndef PWM_SYNC_DEFINES_VH
`define PWM_SYNC_DEFINES_VH

// Register byte offsets
`define OFS_SYNC_START_CTRL   12'h110
`define OFS_SYNC_START_TRIG   12'h114
`define OFS_EVENT_STATUS      12'h120
`define OFS_IRQ_STATUS        12'h130
`define OFS_IRQ_MASK          12'h134
`define OFS_CAPTURE_IN_EN     12'h200

// Reset values
`define RST_SYNC_START_CTRL   32'h0000_0000
`define RST_EVENT_STATUS      32'h0000_0000
`define RST_CAPTURE_IN_EN     32'h0000_0000
`define RST_IRQ_MASK          3'h0

// Field positions
`define BIT_SYNC_START_TRIG   0
`define BIT_SSEN0             0
`define BIT_SSEN2             2
`define BIT_SSEN4             4
`define POS_SYNC_START_SOURCE_SELECT_LO           8
`define POS_SYNC_START_SOURCE_SELECT_HI           9
`define POS_CONV_TRIG_LO      16
`define POS_CONV_TRIG_HI      21
`define BIT_TOP0              0
`define BIT_TOP2              2
`define BIT_TOP4              4
`define POS_CAPEN_HI          5

// Sync start source codes
`define SYNC_START_SOURCE_SELECT_PWM0             2'h0
`define SYNC_START_SOURCE_SELECT_PWM1             2'h1
`define SYNC_START_SOURCE_SELECT_BPWM0            2'h2
`define SYNC_START_SOURCE_SELECT_BPWM1            2'h3

// Counter top value
`define COUNTER_TOP           16'hFFFF

// Interrupt status bits
`define IRQ_SYNC_START        0
`define IRQ_CONV_TRIG         1
`define IRQ_COUNTER_TOP       2

// AXI responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// *** hw/axil_slave_port.v ***
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_defines.vh"

// AXI4-Lite front end: one write and one read in flight, turned into
// single-cycle register strobes for the parent.
module axil_slave_port #(
  parameter AW = 12
) (
  input  wire          clk_i,
  input  wire          nrst_i,
  input  wire [AW-1:0] awaddr_i,
  input  wire          awvalid_i,
  output wire          awready_o,
  input  wire [31:0]   wdata_i,
  input  wire [3:0]    wstrb_i,
  input  wire          wvalid_i,
  output wire          wready_o,
  output wire [1:0]    bresp_o,
  output wire          bvalid_o,
  input  wire          bready_i,
  input  wire [AW-1:0] araddr_i,
  input  wire          arvalid_i,
  output wire          arready_o,
  output wire [31:0]   rdata_o,
  output wire [1:0]    rresp_o,
  output wire          rvalid_o,
  input  wire          rready_i,
  output wire          wr_en_o,
  output wire [AW-1:0] wr_addr_o,
  output wire [31:0]   wr_data_o,
  output wire [3:0]    wr_strb_o,
  input  wire          wr_err_i,
  output wire          rd_en_o,
  output wire [AW-1:0] rd_addr_o,
  input  wire [31:0]   rd_data_i,
  input  wire          rd_err_i
);

  reg          aw_held_r;   // Write address captured
  reg [AW-1:0] aw_addr_r;   // Captured write address
  reg          w_held_r;    // Write data captured
  reg [31:0]   w_data_r;    // Captured write data
  reg [3:0]    w_strb_r;    // Captured byte strobes
  reg          bvalid_r;    // Write response pending
  reg [1:0]    bresp_r;     // Write response code
  reg          rvalid_r;    // Read response pending
  reg [31:0]   rdata_r;     // Read data
  reg [1:0]    rresp_r;     // Read response code

  // Channels accept only while nothing is pending on that side
  assign awready_o = ~aw_held_r & ~bvalid_r;
  assign wready_o  = ~w_held_r & ~bvalid_r;
  assign arready_o = ~rvalid_r;

  // Register strobes towards the parent
  assign wr_en_o   = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_addr_o = aw_addr_r;
  assign wr_data_o = w_data_r;
  assign wr_strb_o = w_strb_r;
  assign rd_en_o   = arvalid_i & ~rvalid_r;
  assign rd_addr_o = araddr_i;

  assign bvalid_o = bvalid_r;
  assign bresp_o  = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o  = rdata_r;
  assign rresp_o  = rresp_r;

  // Write address and data capture, in either order
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= {AW{1'b0}};
      w_held_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_held_r <= 1'b1;
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
      end
      // Both halves present: commit and answer
      if (wr_en_o) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_r && bready_i) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read: data sampled on the address handshake
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `RESP_OKAY;
    end else if (rd_en_o) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_data_i;
      rresp_r  <= rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
    end else if (rvalid_r && rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

endmodule // axil_slave_port
`default_nettype wire

// *** hw/pwm_sync_start_status_capture_gate.v ***
// Function
// RULE1: Trigger write sets enabled channels' run enables
// RULE2: Both instances start in the same cycle
// RULE3: Trigger is write-only bit 0, rest reserved
// RULE4: Trigger exists only in first instance
// RULE5: Sticky conversion trigger flags, write 1 clears
// RULE6: Sticky counter top flag until write 1
// RULE7: Top flags only for counters 0, 2, 4
// RULE8: Disabled capture path feeds constant zero
// RULE9: Enabled capture path passes pin signal
// RULE10: Even channel sync enable gates the start
// RULE11: Two-bit source select picks start origin
// RULE12: Writing 0 does nothing; trigger reads zero
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_sync_defines.vh"

module pwm_sync_start_status_capture_gate #(
  parameter NCH = 6,   // Channels per instance
  parameter CW  = 16   // Time-base counter width
) (
  input  wire              clk_i,
  input  wire              nrst_i,
  // AXI4-Lite slave
  input  wire [11:0]       s_axi_awaddr_i,
  input  wire              s_axi_awvalid_i,
  output wire              s_axi_awready_o,
  input  wire [31:0]       s_axi_wdata_i,
  input  wire [3:0]        s_axi_wstrb_i,
  input  wire              s_axi_wvalid_i,
  output wire              s_axi_wready_o,
  output wire [1:0]        s_axi_bresp_o,
  output wire              s_axi_bvalid_o,
  input  wire              s_axi_bready_i,
  input  wire [11:0]       s_axi_araddr_i,
  input  wire              s_axi_arvalid_i,
  output wire              s_axi_arready_o,
  output wire [31:0]       s_axi_rdata_o,
  output wire [1:0]        s_axi_rresp_o,
  output wire              s_axi_rvalid_o,
  input  wire              s_axi_rready_i,
  // Second instance sync control and external start sources
  input  wire [2:0]        sync_start_enable_inst1_i,
  input  wire [1:0]        sync_start_source_select_inst1_i,
  input  wire              pwm1_start_pulse_i,
  input  wire              bpwm0_start_pulse_i,
  input  wire              bpwm1_start_pulse_i,
  // Run enable set pulses for both instances
  output wire [NCH-1:0]    counter_run_enable_set_inst0_o,
  output wire [NCH-1:0]    counter_run_enable_set_inst1_o,
  // Event inputs of this instance
  input  wire [NCH-1:0]    conv_trigger_pulse_i,
  input  wire [3*CW-1:0]   counter_value_i,
  // Capture path
  input  wire [NCH-1:0]    capture_pin_i,
  output wire [NCH-1:0]    capture_in_o,
  // Interrupt
  output wire              irq_o
);

  // Bus strobes from the front end
  wire        wr_en;       // Write commit pulse
  wire [11:0] wr_addr;     // Write address
  wire [31:0] wr_data;     // Write data
  wire [3:0]  wr_strb;     // Byte strobes
  wire        rd_en;       // Read pulse
  wire [11:0] rd_addr;     // Read address
  reg  [31:0] rd_data;     // Read mux
  reg         rd_err;      // Unmapped read
  reg         wr_err;      // Unmapped write

  // Registers
  reg [2:0]       sync_start_enable_r;        // Even channel enables
  reg [1:0]       sync_start_source_select_r; // Start origin
  reg [NCH-1:0]   conv_trigger_flag_r;        // Sticky conversion flags
  reg [2:0]       counter_top_flag_r;         // Sticky top flags 0,2,4
  reg [NCH-1:0]   capture_path_enable_r;      // Capture gates
  reg [NCH-1:0]   capture_in_r;               // Gated capture inputs
  reg [NCH-1:0]   run_set0_r;                 // Instance 0 start pulses
  reg [NCH-1:0]   run_set1_r;                 // Instance 1 start pulses
  reg [2:0]       irq_status_r;               // Read-clear interrupt flags
  reg [2:0]       irq_mask_r;                 // Interrupt mask

  // Byte-strobe expanded write data
  wire [31:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [31:0] wbits = wr_data & wmask;

  // Address hits for writes, and for the interrupt status read
  wire wr_ctrl = wr_en & (wr_addr == `OFS_SYNC_START_CTRL);
  wire wr_trig = wr_en & (wr_addr == `OFS_SYNC_START_TRIG);
  wire wr_stat = wr_en & (wr_addr == `OFS_EVENT_STATUS);
  wire wr_cap  = wr_en & (wr_addr == `OFS_CAPTURE_IN_EN);
  wire wr_mask = wr_en & (wr_addr == `OFS_IRQ_MASK);
  wire rd_irq  = rd_en & (rd_addr == `OFS_IRQ_STATUS);

  // Software trigger: only a 1 in bit 0 with its byte enabled counts
  wire sw_trigger = wr_trig & wbits[`BIT_SYNC_START_TRIG]; // RULE3 RULE12 RULE4

  axil_slave_port #(
    .AW (12)
  ) u_bus (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .wr_en_o   (wr_en),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (wr_err),
    .rd_en_o   (rd_en),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  // Select start origin from a source code
  function sel_source;
    input [1:0] code;
    input       own;
    begin
      case (code)
        `SYNC_START_SOURCE_SELECT_PWM0:  sel_source = own;                 // RULE11
        `SYNC_START_SOURCE_SELECT_PWM1:  sel_source = pwm1_start_pulse_i;  // RULE11
        `SYNC_START_SOURCE_SELECT_BPWM0: sel_source = bpwm0_start_pulse_i; // RULE11
        `SYNC_START_SOURCE_SELECT_BPWM1: sel_source = bpwm1_start_pulse_i; // RULE11
        default:     sel_source = 1'b0;
      endcase
    end
  endfunction

  // Start pulse seen by each instance
  wire start0 = sel_source(sync_start_source_select_r, sw_trigger);
  wire start1 = sel_source(sync_start_source_select_inst1_i, sw_trigger);

  // Counter top detection for counters 0, 2, 4
  wire [2:0] top_hit;
  wire [NCH-1:0] start_set0;
  wire [NCH-1:0] start_set1;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_even
      assign top_hit[g] = (counter_value_i[g*CW +: CW] == `COUNTER_TOP); // RULE6 RULE7
      // Even channel enabled by its sync bit; odd channel has none
      assign start_set0[2*g]   = start0 & sync_start_enable_r[g];       // RULE1 RULE10
      assign start_set0[2*g+1] = 1'b0;
      assign start_set1[2*g]   = start1 & sync_start_enable_inst1_i[g]; // RULE1 RULE10
      assign start_set1[2*g+1] = 1'b0;
    end
  endgenerate

  // Control register and mask
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_start_enable_r        <= 3'h0;
      sync_start_source_select_r <= 2'h0;
      capture_path_enable_r      <= {NCH{1'b0}};
      irq_mask_r                 <= `RST_IRQ_MASK;
    end else begin
      // Sync start enables and source
      if (wr_ctrl) begin
        if (wr_strb[0]) begin
          sync_start_enable_r <= {wr_data[`BIT_SSEN4], wr_data[`BIT_SSEN2],
                                  wr_data[`BIT_SSEN0]};
        end
        if (wr_strb[1]) begin
          sync_start_source_select_r <= wr_data[`POS_SYNC_START_SOURCE_SELECT_HI:`POS_SYNC_START_SOURCE_SELECT_LO];
        end
      end
      // Capture enables
      if (wr_cap && wr_strb[0]) begin
        capture_path_enable_r <= wr_data[`POS_CAPEN_HI:0];
      end
      // Interrupt mask
      if (wr_mask && wr_strb[0]) begin
        irq_mask_r <= wr_data[2:0];
      end
    end
  end

  // Run enable set pulses, registered so both instances align
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run_set0_r <= {NCH{1'b0}};
      run_set1_r <= {NCH{1'b0}};
    end else begin
      run_set0_r <= start_set0; // RULE2
      run_set1_r <= start_set1; // RULE2
    end
  end

  assign counter_run_enable_set_inst0_o = run_set0_r;
  assign counter_run_enable_set_inst1_o = run_set1_r;

  // Sticky event flags, set wins over write-one clear
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_trigger_flag_r <= {NCH{1'b0}};
      counter_top_flag_r  <= 3'h0;
    end else begin
      conv_trigger_flag_r <= (conv_trigger_flag_r
                              & ~({NCH{wr_stat}} & wbits[`POS_CONV_TRIG_HI:`POS_CONV_TRIG_LO]))
                             | conv_trigger_pulse_i; // RULE5
      counter_top_flag_r  <= (counter_top_flag_r
                              & ~({3{wr_stat}} & {wbits[`BIT_TOP4], wbits[`BIT_TOP2],
                                                  wbits[`BIT_TOP0]}))
                             | top_hit; // RULE6 RULE7
    end
  end

  // Interrupt flags, cleared by reading, set wins
  wire [2:0] irq_events = {|top_hit, |conv_trigger_pulse_i, start0 | start1};
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status_r <= 3'h0;
    end else begin
      irq_status_r <= (irq_status_r & ~{3{rd_irq}}) | irq_events;
    end
  end

  assign irq_o = |(irq_status_r & irq_mask_r);

  // Capture gate: zero when disabled, pin when enabled
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_in_r <= {NCH{1'b0}};
    end else begin
      capture_in_r <= capture_pin_i & capture_path_enable_r; // RULE8 RULE9
    end
  end

  assign capture_in_o = capture_in_r;

  // Read mux and decode errors
  always @* begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (rd_addr)
      // Enables and source select
      `OFS_SYNC_START_CTRL: begin
        rd_data[`BIT_SSEN0] = sync_start_enable_r[0];
        rd_data[`BIT_SSEN2] = sync_start_enable_r[1];
        rd_data[`BIT_SSEN4] = sync_start_enable_r[2];
        rd_data[`POS_SYNC_START_SOURCE_SELECT_HI:`POS_SYNC_START_SOURCE_SELECT_LO] = sync_start_source_select_r;
      end
      // Write-only trigger reads zero
      `OFS_SYNC_START_TRIG: begin
        rd_data = 32'h0000_0000; // RULE12 RULE3
      end
      // Event flags; reserved bits stay zero
      `OFS_EVENT_STATUS: begin
        rd_data[`POS_CONV_TRIG_HI:`POS_CONV_TRIG_LO] = conv_trigger_flag_r;
        rd_data[`BIT_TOP0] = counter_top_flag_r[0];
        rd_data[`BIT_TOP2] = counter_top_flag_r[1];
        rd_data[`BIT_TOP4] = counter_top_flag_r[2];
      end
      // Interrupt flags
      `OFS_IRQ_STATUS: begin
        rd_data[2:0] = irq_status_r;
      end
      // Interrupt mask
      `OFS_IRQ_MASK: begin
        rd_data[2:0] = irq_mask_r;
      end
      // Capture enables
      `OFS_CAPTURE_IN_EN: begin
        rd_data[`POS_CAPEN_HI:0] = capture_path_enable_r;
      end
      // Unmapped
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // Write decode error
  always @* begin
    case (wr_addr)
      `OFS_SYNC_START_CTRL: wr_err = 1'b0;
      `OFS_SYNC_START_TRIG: wr_err = 1'b0;
      `OFS_EVENT_STATUS:    wr_err = 1'b0;
      `OFS_IRQ_STATUS:      wr_err = 1'b0;
      `OFS_IRQ_MASK:        wr_err = 1'b0;
      `OFS_CAPTURE_IN_EN:   wr_err = 1'b0;
      default:              wr_err = 1'b1;
    endcase
  end

endmodule // pwm_sync_start_status_capture_gate
`default_nettype wire

// *** dv/pwm_gate_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level watcher for the sync start, status and capture gate block
module pwm_gate_props #(
  parameter NCH = 6,
  parameter CW  = 16
) (
  input wire logic            clk_i,
  input wire logic            nrst_i,
  input wire logic [11:0]     s_axi_awaddr_i,
  input wire logic            s_axi_awvalid_i,
  input wire logic            s_axi_awready_o,
  input wire logic            s_axi_wvalid_i,
  input wire logic            s_axi_wready_o,
  input wire logic [1:0]      s_axi_bresp_o,
  input wire logic            s_axi_bvalid_o,
  input wire logic            s_axi_bready_i,
  input wire logic [11:0]     s_axi_araddr_i,
  input wire logic            s_axi_arvalid_i,
  input wire logic            s_axi_arready_o,
  input wire logic [31:0]     s_axi_rdata_o,
  input wire logic [1:0]      s_axi_rresp_o,
  input wire logic            s_axi_rvalid_o,
  input wire logic            s_axi_rready_i,
  input wire logic [2:0]      sync_start_enable_inst1_i,
  input wire logic            pwm1_start_pulse_i,
  input wire logic            bpwm0_start_pulse_i,
  input wire logic            bpwm1_start_pulse_i,
  input wire logic [NCH-1:0]  counter_run_enable_set_inst0_o,
  input wire logic [NCH-1:0]  counter_run_enable_set_inst1_o,
  input wire logic [NCH-1:0]  capture_pin_i,
  input wire logic [NCH-1:0]  capture_in_o,
  input wire logic            irq_o
);
  logic       ar_hs;   // Read address taken
  logic       ext_any; // Any outside start pulse
  logic [5:0] en1_map; // Second instance enables on even channels
  assign ar_hs   = s_axi_arvalid_i && s_axi_arready_o;
  assign ext_any = pwm1_start_pulse_i || bpwm0_start_pulse_i || bpwm1_start_pulse_i;
  assign en1_map = {1'b0, sync_start_enable_inst1_i[2], 1'b0,
                    sync_start_enable_inst1_i[1], 1'b0, sync_start_enable_inst1_i[0]};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  odd_quiet_a: assert property (
    ((counter_run_enable_set_inst0_o[5:0] | counter_run_enable_set_inst1_o[5:0]) & 6'h2A) == 6'h00)
    else $error("odd channel run enable pulsed");
  inst1_gate_a: assert property (
    |counter_run_enable_set_inst1_o |-> (counter_run_enable_set_inst1_o[5:0] & ~$past(en1_map)) == 6'h00)
    else $error("second instance pulse without its enable");
  pulse_single_a: assert property (
    |counter_run_enable_set_inst0_o |=> counter_run_enable_set_inst0_o == '0)
    else $error("run enable pulse longer than one cycle");
  pulse_cause_a: assert property (
    |counter_run_enable_set_inst0_o |-> s_axi_bvalid_o || $past(ext_any))
    else $error("run enable pulse without a start cause");
  capture_pin_a: assert property (
    (capture_in_o & ~$past(capture_pin_i)) == '0)
    else $error("capture input high without its pin");
  trig_zero_a: assert property (
    ar_hs && s_axi_araddr_i == 12'h114 |=> s_axi_rdata_o == 32'h0000_0000 && s_axi_rresp_o == 2'h0)
    else $error("trigger register read not zero");
  unmapped_err_a: assert property (
    ar_hs && s_axi_araddr_i == 12'h300 |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  write_answer_a: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  bresp_hold_a: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");

  cover property (|counter_run_enable_set_inst0_o && |counter_run_enable_set_inst1_o);
  cover property (irq_o);
  cover property (capture_in_o != '0);
endmodule // pwm_gate_props

bind pwm_sync_start_status_capture_gate pwm_gate_props #(.NCH(NCH), .CW(CW)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(s_axi_awaddr_i),
  .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
  .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .sync_start_enable_inst1_i(sync_start_enable_inst1_i),
  .pwm1_start_pulse_i(pwm1_start_pulse_i), .bpwm0_start_pulse_i(bpwm0_start_pulse_i),
  .bpwm1_start_pulse_i(bpwm1_start_pulse_i),
  .counter_run_enable_set_inst0_o(counter_run_enable_set_inst0_o),
  .counter_run_enable_set_inst1_o(counter_run_enable_set_inst1_o),
  .capture_pin_i(capture_pin_i), .capture_in_o(capture_in_o), .irq_o(irq_o));
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i, nrst_i, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  r, src1;
  logic [2:0]  en1, ext;
  logic [5:0]  conv, pin, last0, last1;
  logic [47:0] cnt;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0]   bresp, rresp;
  wire [31:0]  rdata;
  wire [5:0]   run0, run1, capin;
  int          mismatches, tests_run, npulse;

  pwm_sync_start_status_capture_gate DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .sync_start_enable_inst1_i(en1), .sync_start_source_select_inst1_i(src1),
    .pwm1_start_pulse_i(ext[0]), .bpwm0_start_pulse_i(ext[1]), .bpwm1_start_pulse_i(ext[2]),
    .counter_run_enable_set_inst0_o(run0), .counter_run_enable_set_inst1_o(run1),
    .conv_trigger_pulse_i(conv), .counter_value_i(cnt), .capture_pin_i(pin),
    .capture_in_o(capin), .irq_o(irq));

  // Free-running 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Log run enable pulses of both instances seen in one cycle
  always @(negedge clk_i) begin
    if (|run0 || |run1) begin
      last0 = run0;
      last1 = run1;
      npulse++;
    end
  end

  // Even-channel spread of three enables
  function automatic logic [5:0] ev(input logic [2:0] e);
    ev = {1'b0, e[2], 1'b0, e[1], 1'b0, e[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    logic aok, wok, bok;
    n = 0;
    bok = 1'b0;
    @(posedge clk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= s; wvalid <= 1'b1;
    while (!bok && n < 64) begin
      @(negedge clk_i);
      aok = awvalid && awready;
      wok = wvalid && wready;
      bok = bvalid && bready;
      r = bresp;
      @(posedge clk_i);
      if (aok) awvalid <= 1'b0;
      if (wok) wvalid <= 1'b0;
      // Late bready so the response must hold
      if (bvalid && !bok) bready <= 1'b1;
      n++;
    end
    bready <= 1'b0;
    check("write answer", bok, 1);
  endtask

  // Bus read
  task automatic rd(input logic [11:0] a);
    int n;
    logic aok, rok;
    n = 0;
    rok = 1'b0;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1;
    while (!rok && n < 64) begin
      @(negedge clk_i);
      aok = arvalid && arready;
      rok = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clk_i);
      if (aok) arvalid <= 1'b0;
      // Late rready so the read data must hold
      if (rvalid && !rok) rready <= 1'b1;
      n++;
    end
    rready <= 1'b0;
    check("read answer", rok, 1);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard
  initial begin
    #5_000_000;
    mismatches++;
    report_and_stop;
  end

  logic [11:0] map [6] = '{12'h110, 12'h114, 12'h120, 12'h130, 12'h134, 12'h200};
  logic [5:0]  cen [3] = '{6'h2A, 6'h15, 6'h3F};
  logic [5:0]  cpn [3] = '{6'h3F, 6'h3F, 6'h0C};
  logic [2:0]  sel [3] = '{3'b001, 3'b100, 3'b000};

  initial begin
    {nrst_i, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} = '0;
    {wdata, wstrb, src1, en1, ext, conv, pin, cnt} = '0;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    foreach (map[i]) begin
      rd(map[i]);
      check("reset value", d, 32'h0000_0000);
    end
    wr(12'h200, 32'hFFFF_FFFF, 4'hF);
    wr(12'h200, 32'h0000_0000, 4'h2);
    rd(12'h200);
    check("capture enable", d, 32'h0000_003F);
    wr(12'h110, 32'hFFFF_FFFF, 4'hF);
    rd(12'h110);
    check("sync control", d, 32'h0000_0315);
    foreach (cen[i]) begin
      wr(12'h200, {26'h0, cen[i]}, 4'hF);
      pin <= cpn[i];
      repeat (3) @(posedge clk_i);
      check("capture path", {26'h0, capin}, {26'h0, cen[i] & cpn[i]});
    end
    en1 <= 3'b101;
    for (int s = 0; s < 4; s++) begin
      wr(12'h110, 32'h0000_0015 | (s << 8), 4'hF);
      src1 <= s[1:0];
      npulse = 0;
      wr(12'h114, 32'h0000_0001, 4'hF);
      repeat (3) @(posedge clk_i);
      check("trigger pulses", npulse, s == 0);
      if (s != 0) begin
        npulse = 0;
        ext <= 3'b001 << (s - 1);
        @(posedge clk_i);
        ext <= 3'b000;
        repeat (3) @(posedge clk_i);
        check("outside start pulses", npulse, 1);
      end
      check("first run enables", last0, 6'h15);
      check("second run enables", last1, 6'h11);
    end
    src1 <= 2'h0;
    en1 <= 3'b000;
    foreach (sel[i]) begin
      wr(12'h110, {26'h0, ev(sel[i])}, 4'hF);
      npulse = 0;
      wr(12'h114, 32'h0000_0001, 4'hF);
      wr(12'h114, 32'h0000_0000, 4'hF);
      wr(12'h114, 32'hFFFF_FFFE, 4'hF);
      repeat (3) @(posedge clk_i);
      check("enabled start count", npulse, sel[i] != 0);
      if (sel[i] != 0) check("enabled channels", last0, ev(sel[i]));
    end
    rd(12'h114);
    check("trigger readback", d, 32'h0000_0000);
    rd(12'h130);
    conv <= 6'h21;
    @(posedge clk_i);
    conv <= 6'h00;
    cnt <= {16'h0000, 16'hFFFF, 16'hFFFE};
    @(posedge clk_i);
    cnt <= '0;
    rd(12'h120);
    check("status flags", d, 32'h0021_0004);
    cnt <= {48{1'b1}};
    @(posedge clk_i);
    cnt <= '0;
    rd(12'h120);
    check("top flags", d, 32'h0021_0015);
    wr(12'h120, 32'h0001_0004, 4'hF);
    rd(12'h120);
    check("partial clear", d, 32'h0020_0011);
    wr(12'h120, 32'hFFFF_FFFF, 4'hF);
    rd(12'h120);
    check("full clear", d, 32'h0000_0000);
    rd(12'h130);
    wr(12'h134, 32'h0000_0004, 4'hF);
    cnt <= {48{1'b1}};
    @(posedge clk_i);
    cnt <= '0;
    repeat (3) @(posedge clk_i);
    check("irq raised", irq, 1'b1);
    rd(12'h130);
    check("irq status", d, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    check("irq cleared", irq, 1'b0);
    wr(12'h134, 32'h0000_0001, 4'hF);
    conv <= 6'h01;
    @(posedge clk_i);
    conv <= 6'h00;
    repeat (3) @(posedge clk_i);
    check("irq masked", irq, 1'b0);
    rd(12'h130);
    check("masked status", d, 32'h0000_0002);
    rd(12'h300);
    check("unmapped read resp", r, 2'h2);
    wr(12'h300, 32'hFFFF_FFFF, 4'hF);
    check("unmapped write resp", r, 2'h2);
    report_and_stop;
  end
endmodule // tb_top
`default_nettype wire
